//--- bench/sadc_core_sva.sv
// Assertion checker bound to the converter control block ports
`timescale 1ns/1ps
module sadc_core_sva (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Serial pins
    input wire logic CS_N_I,
    input wire logic SCLK_I,
    input wire logic SDO_O,
    input wire logic SDO_OE_O,
    // Front end status
    input wire logic SAMPLE_CONNECT_O,
    input wire logic CAL_REF_SEL_O,
    input wire logic ACQ_READY_O
);
    logic cs_q;
    logic sclk_q;
    logic first_done_r;
    logic [3:0] quiet_r;
    // Cycles since the last pin change; the output may only move shortly after one
    always_ff @(posedge CLK_SYS_I) begin
        cs_q <= CS_N_I;
        sclk_q <= SCLK_I;
        quiet_r <= (RST_I || cs_q != CS_N_I || sclk_q != SCLK_I) ? 4'h0
            : quiet_r + {3'h0, quiet_r != 4'hF};
    end
    // First frame after power-up ends at its select rise
    always_ff @(posedge CLK_SYS_I) begin
        first_done_r <= RST_I ? 1'b0 : (first_done_r | (!cs_q & CS_N_I));
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    oe_open_a: assert property ($fell(CS_N_I) |-> ##[1:5] (SDO_OE_O && !SDO_O))
        else $error("output not enabled low after select fall");
    oe_close_a: assert property ($rose(CS_N_I) |-> ##[1:5] !SDO_OE_O)
        else $error("output not released after select rise");
    idle_off_a: assert property (CS_N_I [*6] |-> !SDO_OE_O && !CAL_REF_SEL_O)
        else $error("output or calibration active outside a frame");
    sclk_only_a: assert property ($changed(SDO_O) |-> quiet_r <= 4'h5)
        else $error("serial output moved without a pin edge");
    pwrup_low_a: assert property (!first_done_r |-> !SDO_O)
        else $error("serial output high in first frame");
    cal_iso_a: assert property (CAL_REF_SEL_O |-> !SAMPLE_CONNECT_O)
        else $error("inputs connected during calibration");
    conv_iso_a: assert property ($fell(CS_N_I) |-> ##[1:5] !SAMPLE_CONNECT_O)
        else $error("inputs not disconnected at conversion start");
    idle_conn_a: assert property (CS_N_I [*6] |-> SAMPLE_CONNECT_O)
        else $error("inputs not reconnected outside a frame");
    acq_wait_a: assert property ($rose(SAMPLE_CONNECT_O) |-> !ACQ_READY_O [*8])
        else $error("ready raised too early after reconnect");
    cover property ($rose(CAL_REF_SEL_O));
    cover property ($fell(SDO_OE_O));
    cover property ($rose(ACQ_READY_O));
endmodule
bind sadc_core sadc_core_sva CHK (.CLK_SYS_I, .RST_I, .CS_N_I, .SCLK_I, .SDO_O, .SDO_OE_O,
    .SAMPLE_CONNECT_O, .CAL_REF_SEL_O, .ACQ_READY_O);

//--- bench/sadc_host_model.sv
// Host serial master model that frames conversions for the converter block
`timescale 1ns/1ps
module sadc_host_model #(
    parameter int HALF = 8
) (
    // Clock and returned data
    input wire logic clk_i,
    input wire logic sdo_i,
    // Serial pins and captured bits
    output logic cs_n_o,
    output logic sclk_o,
    output logic [31:0] bits_o
);
    // Serial clock rests low between frames
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        bits_o = 32'h0;
    end
    // One frame of n falling edges; sampled just before each fall, while data is settled
    task automatic frame(input int n);
        cs_n_o <= 1'b0;
        bits_o <= 32'h0;
        repeat (4) @(posedge clk_i);
        for (int k = 0; k < n; k++) begin
            sclk_o <= 1'b1;
            repeat (HALF) @(posedge clk_i);
            bits_o <= {bits_o[30:0], sdo_i};
            sclk_o <= 1'b0;
            repeat (HALF) @(posedge clk_i);
        end
        cs_n_o <= 1'b1;
        repeat (60) @(posedge clk_i);
    endtask
endmodule

//--- bench/test_sadc_core.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_sadc_core;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic comp = 1'b0;
    logic sdo, sdo_oe, conn, cal_ref, acq_rdy, cs_n, sclk;
    logic [sadc_pkg::RES_W-1:0] dac;
    logic [31:0] bits;
    int vin = 0;
    int aoff = 5;
    int fails = 0;
    int cmp_count = 0;
    initial forever #2.5 clk = ~clk;
    // Analog front end: input or mid-scale reference, shifted by a front-end offset
    always @(posedge clk) begin
        comp <= ((cal_ref === 1'b1 ? 512 : vin) + aoff) >= int'(dac);
    end
    sadc_core DUT (.CLK_SYS_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCLK_I(sclk), .SDO_O(sdo),
        .SDO_OE_O(sdo_oe), .COMP_I(comp), .DAC_CODE_O(dac), .SAMPLE_CONNECT_O(conn),
        .CAL_REF_SEL_O(cal_ref), .ACQ_READY_O(acq_rdy));
    // A released data line reads as the inverse of the expected zeros
    sadc_host_model HOST (.clk_i(clk), .sdo_i(sdo_oe ? sdo : 1'b1), .cs_n_o(cs_n), .sclk_o(sclk),
        .bits_o(bits));
    // One frame; whole frame pattern compared so leading and trailing zeros count too
    task automatic conv(input int n, input int v, input int e, input string nm);
        vin = v;
        HOST.frame(n);
        `CHK(nm, 32'(e) << (n - 12), bits)
        `CHK("enable", 1'b0, sdo_oe)
        `CHK("connect", 1'b1, conn)
        `CHK("ready", 1'b1, acq_rdy)
    endtask
    // Short first frame: output low and store left at zero
    task automatic t_pwrup_short();
        vin = 'h123;
        HOST.frame(8);
        `CHK("first", 32'h0, bits)
        conv(12, 'h123, 'h128, "uncal");
        $display("Test pwrup_short done");
    endtask
    // In-frame calibration, then every ideal code through the corrected path
    task automatic t_recal();
        conv(32, 'h123, 'h128, "recal");
        conv(12, 'h000, 'h000, "c000");
        conv(12, 'h001, 'h001, "c001");
        conv(12, 'h200, 'h200, "c200");
        conv(12, 'h201, 'h201, "c201");
        conv(12, 'h3FF, 'h3FF, "c3ff");
        conv(12, 'h155, 'h155, "c155");
        $display("Test recal done");
    endtask
    // A frame one edge short of recalibration must keep the old offset
    task automatic t_short_recal();
        aoff = 9;
        conv(31, 'h2AA, 'h2AE, "short31");
        conv(12, 'h2AA, 'h2AE, "kept");
        $display("Test short_recal done");
    endtask
    // Only a power-up reset rearms the power-up calibration
    task automatic t_reset_cal();
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        conv(16, 'h040, 'h000, "pwrcal");
        conv(12, 'h040, 'h040, "after");
        $display("Test reset_cal done");
    endtask
    task automatic report_and_stop();
        $display("Counts: %0d compared, %0d mismatched", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence; the host cuts the power-up calibration short, recalibrates in a frame, leaves a drift uncorrected, then calibrates after a reset
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_pwrup_short();
        t_recal();
        t_short_recal();
        t_reset_cal();
        report_and_stop();
    end
    // Watchdog: the whole sequence needs under ten thousand cycles
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule

//--- rtl/sadc_core.sv
// Digital control of the serial-framed SAR converter with offset calibration
`timescale 1ns/1ps
module sadc_core (
    // System clock and power-up reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Serial interface pins from the host
    input wire logic CS_N_I,
    input wire logic SCLK_I,
    // Serial data pin, two signals of a tri-state output
    output logic SDO_O,
    output logic SDO_OE_O,
    // Analog front end
    input wire logic COMP_I,
    output logic [sadc_pkg::RES_W-1:0] DAC_CODE_O,
    output logic SAMPLE_CONNECT_O,
    output logic CAL_REF_SEL_O,
    output logic ACQ_READY_O
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] pins_s;
    logic cs_n_s;
    logic sclk_s;
    logic comp_s;
    logic cs_prev_r;
    logic sclk_prev_r;
    logic frame_open;
    logic frame_close;
    logic sclk_fall;
    logic [sadc_pkg::CNT_W-1:0] edge_cnt_r;
    logic [sadc_pkg::CNT_W-1:0] edge_nxt;
    logic pwrup_pending_r;
    logic [sadc_pkg::STORE_W-1:0] offset_correction_store_r;
    logic [sadc_pkg::STORE_W-1:0] cal_offset;
    sadc_pkg::sadc_phase_t phase_r;
    sadc_pkg::sadc_phase_t phase_nxt;
    logic conv_start;
    logic conv_step;
    logic [sadc_pkg::RES_W-1:0] conv_trial;
    logic conv_done;
    logic cal_start;
    logic cal_step;
    logic [sadc_pkg::STORE_W-1:0] cal_trial;
    logic cal_done;
    logic cal_commit;
    logic sdo_r;
    logic sdo_oe_r;
    logic [sadc_pkg::RES_W-1:0] dac_r;
    logic [sadc_pkg::RES_W-1:0] dac_nxt;
    logic connect_r;
    logic cal_ref_r;
    logic [sadc_pkg::ACQ_W-1:0] acq_cnt_r;
    logic acq_ready_r;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Phases in which the sampling stage is cut off from the inputs
    function automatic logic is_isolated(input sadc_pkg::sadc_phase_t st);
        logic iso;
        case (st)
            sadc_pkg::FR_CONVERT: iso = 1'b1;
            sadc_pkg::FR_PWRUP_CAL: iso = 1'b1;
            sadc_pkg::FR_RECAL: iso = 1'b1;
            default: iso = 1'b0;
        endcase
        return iso;
    endfunction

    // Phases in which the calibration reference replaces the inputs
    function automatic logic is_cal(input sadc_pkg::sadc_phase_t st);
        logic cal;
        case (st)
            sadc_pkg::FR_PWRUP_CAL: cal = 1'b1;
            sadc_pkg::FR_RECAL: cal = 1'b1;
            default: cal = 1'b0;
        endcase
        return cal;
    endfunction

    // Trial code shifted by a signed offset, clamped to the code range
    function automatic logic [sadc_pkg::RES_W-1:0] shift_code(
        input logic [sadc_pkg::RES_W-1:0] code,
        input logic [sadc_pkg::STORE_W-1:0] offs
    );
        logic signed [sadc_pkg::RES_W+1:0] sum;
        logic [sadc_pkg::RES_W-1:0] res;
        sum = $signed({2'b00, code}) +
            $signed({{(sadc_pkg::RES_W+2-sadc_pkg::STORE_W){offs[sadc_pkg::STORE_W-1]}}, offs});
        if (sum < 0) begin
            res = sadc_pkg::CODE_NEG_FULL;
        end else if (sum > $signed({2'b00, sadc_pkg::CODE_POS_FULL})) begin
            res = sadc_pkg::CODE_POS_FULL;
        end else begin
            res = sum[sadc_pkg::RES_W-1:0];
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Select idles high so the reset value must not look like a frame
    sadc_sync2 #(
        .W(3),
        .INIT(3'h6)
    ) u_pin_sync (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .async_i({CS_N_I, SCLK_I, COMP_I}),
        .sync_o(pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign comp_s = pins_s[0];

    // ------------------------------------------------------------
    // Edge detection on synchronised pins
    // ------------------------------------------------------------
    // Edge history registers for select and serial clock
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            cs_prev_r <= 1'b1;
            sclk_prev_r <= 1'b1;
        end else begin
            cs_prev_r <= cs_n_s;
            sclk_prev_r <= sclk_s;
        end
    end

    // Frame bounds come from select edges only
    assign frame_open = cs_prev_r & ~cs_n_s;
    assign frame_close = ~cs_prev_r & cs_n_s;
    // Serial clock edges count only inside an open frame
    assign sclk_fall = sclk_prev_r & ~sclk_s & ~cs_n_s & ~frame_close &
        (phase_r != sadc_pkg::FR_IDLE);

    // ------------------------------------------------------------
    // Falling edge counter
    // ------------------------------------------------------------
    // Saturates so that very long frames cannot wrap into the schedule
    assign edge_nxt = (edge_cnt_r == sadc_pkg::EDGE_MAX) ? edge_cnt_r :
        edge_cnt_r + 1'b1;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            edge_cnt_r <= sadc_pkg::EDGE_NONE;
        end else if (frame_open) begin
            edge_cnt_r <= sadc_pkg::EDGE_NONE;
        end else if (sclk_fall) begin
            edge_cnt_r <= edge_nxt;
        end
    end

    // ------------------------------------------------------------
    // Power-up calibration marker
    // ------------------------------------------------------------
    // Cleared by the first frame whether or not it ran long enough
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            pwrup_pending_r <= 1'b1;
        end else if (frame_open) begin
            pwrup_pending_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Frame phase sequencer
    // ------------------------------------------------------------
    // Select rising has priority over any clock edge in the same cycle
    always_comb begin
        phase_nxt = phase_r;
        if (frame_close) begin
            phase_nxt = sadc_pkg::FR_IDLE;
        end else begin
            case (phase_r)
                sadc_pkg::FR_IDLE: begin
                    if (frame_open && pwrup_pending_r) begin
                        phase_nxt = sadc_pkg::FR_PWRUP_CAL;
                    end else if (frame_open) begin
                        phase_nxt = sadc_pkg::FR_CONVERT;
                    end
                end
                sadc_pkg::FR_CONVERT: begin
                    if (sclk_fall && edge_nxt == sadc_pkg::EDGE_CONV_DONE) begin
                        phase_nxt = sadc_pkg::FR_TRAIL;
                    end
                end
                sadc_pkg::FR_TRAIL: begin
                    if (sclk_fall && edge_nxt == sadc_pkg::EDGE_RECAL_START) begin
                        phase_nxt = sadc_pkg::FR_RECAL;
                    end
                end
                sadc_pkg::FR_RECAL: begin
                    if (sclk_fall && edge_nxt == sadc_pkg::EDGE_RECAL_DONE) begin
                        phase_nxt = sadc_pkg::FR_DONE;
                    end
                end
                sadc_pkg::FR_PWRUP_CAL: begin
                    if (sclk_fall && edge_nxt == sadc_pkg::EDGE_PWRUP_CAL_DONE) begin
                        phase_nxt = sadc_pkg::FR_DONE;
                    end
                end
                sadc_pkg::FR_DONE: begin
                    phase_nxt = sadc_pkg::FR_DONE;
                end
                default: begin
                    phase_nxt = sadc_pkg::FR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            phase_r <= sadc_pkg::FR_IDLE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // ------------------------------------------------------------
    // Conversion register
    // ------------------------------------------------------------
    // One decision per falling edge, MSB at the first edge
    assign conv_start = frame_open & ~pwrup_pending_r & (phase_r == sadc_pkg::FR_IDLE);
    assign conv_step = sclk_fall & (phase_r == sadc_pkg::FR_CONVERT);

    sadc_sar #(
        .W(sadc_pkg::RES_W)
    ) u_conv_sar (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .start_i(conv_start),
        .step_i(conv_step),
        .comp_i(comp_s),
        .trial_o(conv_trial),
        .done_o(conv_done)
    );

    // ------------------------------------------------------------
    // Calibration register
    // ------------------------------------------------------------
    // Searches the offset against a mid-scale reference
    assign cal_start = (frame_open & pwrup_pending_r & (phase_r == sadc_pkg::FR_IDLE)) |
        (sclk_fall & (phase_r == sadc_pkg::FR_TRAIL) &
        (edge_nxt == sadc_pkg::EDGE_RECAL_START));
    assign cal_step = sclk_fall & is_cal(phase_r) & ~cal_done;

    sadc_sar #(
        .W(sadc_pkg::STORE_W)
    ) u_cal_sar (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .start_i(cal_start),
        .step_i(cal_step),
        .comp_i(comp_s),
        .trial_o(cal_trial),
        .done_o(cal_done)
    );

    // Offset-binary trial to two's complement offset
    assign cal_offset = {~cal_trial[sadc_pkg::STORE_W-1], cal_trial[sadc_pkg::STORE_W-2:0]};

    // ------------------------------------------------------------
    // Offset correction store
    // ------------------------------------------------------------
    // Written only at the final calibration edge; a short frame leaves it
    assign cal_commit = sclk_fall &
        (((phase_r == sadc_pkg::FR_PWRUP_CAL) && (edge_nxt == sadc_pkg::EDGE_PWRUP_CAL_DONE)) ||
        ((phase_r == sadc_pkg::FR_RECAL) && (edge_nxt == sadc_pkg::EDGE_RECAL_DONE)));

    // No serial path reads or writes this store
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            offset_correction_store_r <= sadc_pkg::STORE_RESET;
        end else if (cal_commit) begin
            offset_correction_store_r <= cal_offset;
        end
    end

    // ------------------------------------------------------------
    // Trial level to the capacitor DAC
    // ------------------------------------------------------------
    // Correction is folded into the trial level so bits leave already
    // corrected; a post-subtraction would break zero-latency shifting
    always_comb begin
        case (phase_r)
            sadc_pkg::FR_CONVERT: begin
                dac_nxt = shift_code(conv_trial, offset_correction_store_r);
            end
            sadc_pkg::FR_PWRUP_CAL, sadc_pkg::FR_RECAL: begin
                dac_nxt = shift_code(sadc_pkg::CODE_MID, cal_offset);
            end
            default: begin
                dac_nxt = sadc_pkg::CODE_MID;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            dac_r <= sadc_pkg::CODE_MID;
        end else begin
            dac_r <= dac_nxt;
        end
    end

    // ------------------------------------------------------------
    // Sampling switch and calibration reference
    // ------------------------------------------------------------
    // Opening the switch at select falling freezes the sample
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            connect_r <= 1'b1;
            cal_ref_r <= 1'b0;
        end else begin
            connect_r <= ~is_isolated(phase_nxt);
            cal_ref_r <= is_cal(phase_nxt);
        end
    end

    // ------------------------------------------------------------
    // Acquisition timer
    // ------------------------------------------------------------
    // Tells the system when the sample window has been long enough;
    // the host still owns the spacing of frames
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            acq_cnt_r <= '0;
            acq_ready_r <= 1'b0;
        end else if (!connect_r) begin
            acq_cnt_r <= '0;
            acq_ready_r <= 1'b0;
        end else if (acq_cnt_r != sadc_pkg::MIN_SAMPLE_CYC) begin
            acq_cnt_r <= acq_cnt_r + 1'b1;
            acq_ready_r <= 1'b0;
        end else begin
            acq_ready_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Serial data output
    // ------------------------------------------------------------
    // Edge 1 sends the second zero, edges 2 to 11 send MSB to LSB;
    // the bit sent at edge k was settled at edge k-1
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else if (frame_close) begin
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else if (frame_open) begin
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b1;
        end else if (sclk_fall) begin
            if (phase_r == sadc_pkg::FR_PWRUP_CAL || pwrup_pending_r) begin
                sdo_r <= 1'b0;
            end else if (edge_nxt <= sadc_pkg::EDGE_SECOND_ZERO) begin
                sdo_r <= 1'b0;
            end else if (edge_nxt >= sadc_pkg::EDGE_HOLD_LOW) begin
                sdo_r <= 1'b0;
            end else begin
                sdo_r <= conv_trial[4'(sadc_pkg::EDGE_LSB - edge_nxt)];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign SDO_O = sdo_r;
    assign SDO_OE_O = sdo_oe_r;
    assign DAC_CODE_O = dac_r;
    assign SAMPLE_CONNECT_O = connect_r;
    assign CAL_REF_SEL_O = cal_ref_r;
    assign ACQ_READY_O = acq_ready_r;

endmodule

//--- rtl/sadc_pkg.sv
// Package of constants and types for the serial-framed SAR converter control block
//
// Behaviour
// - One frame per conversion, select low to high
// - Select falling edge samples input, starts conversion
// - Conversion and shifting paced by serial clock only
// - Leading zero driven at select falling edge
// - Later falling edges shift zero, then result
// - Output held low after twelve clocks
// - Select rising ends frame, output high impedance
// - Inputs disconnected while converting
// - Conversion done reconnects inputs, acquisition begins
// - Results are ten-bit unsigned straight binary
// - Ideal codes 000, 001, 200, 201, 3FF
// - First select fall after power-up starts calibration
// - First frame after power-up outputs only low
// - Offset store unreachable from the serial interface
// - Offset store cleared to zero at power-up
// - Inputs disconnected while calibrating
// - Only power cycle resets calibration state
// - Power-up calibration needs sixteen edges, else unchanged
// - Frame recalibration edges 17 to 32, else unchanged
// - Later results corrected by stored offset
package sadc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int RES_W = 10;
    localparam int STORE_W = 6;
    localparam int CNT_W = 6;
    localparam int ACQ_W = 6;

    // ------------------------------------------------------------
    // Codes of the transfer function
    // ------------------------------------------------------------
    localparam logic [RES_W-1:0] CODE_NEG_FULL = 10'h000;
    localparam logic [RES_W-1:0] CODE_MID = 10'h200;
    localparam logic [RES_W-1:0] CODE_POS_FULL = 10'h3FF;
    localparam logic [STORE_W-1:0] STORE_RESET = 6'h00;

    // ------------------------------------------------------------
    // Serial clock falling edge numbers inside a frame
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] EDGE_NONE = 6'h00;
    localparam logic [CNT_W-1:0] EDGE_SECOND_ZERO = 6'h01;
    localparam logic [CNT_W-1:0] EDGE_CONV_DONE = 6'h0A;
    localparam logic [CNT_W-1:0] EDGE_LSB = 6'h0B;
    localparam logic [CNT_W-1:0] EDGE_HOLD_LOW = 6'h0C;
    localparam logic [CNT_W-1:0] EDGE_PWRUP_CAL_DONE = 6'h10;
    localparam logic [CNT_W-1:0] EDGE_RECAL_START = 6'h11;
    localparam logic [CNT_W-1:0] EDGE_RECAL_DONE = 6'h20;
    localparam logic [CNT_W-1:0] EDGE_MAX = 6'h3F;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_PERIOD_PS = 5000;
    localparam int MIN_SAMPLE_WINDOW_PS = 235000;
    localparam int MIN_SAMPLE_CYC_INT = (MIN_SAMPLE_WINDOW_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    localparam logic [ACQ_W-1:0] MIN_SAMPLE_CYC = ACQ_W'(MIN_SAMPLE_CYC_INT);

    // ------------------------------------------------------------
    // Frame phases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FR_IDLE = 3'b000,
        FR_PWRUP_CAL = 3'b001,
        FR_CONVERT = 3'b010,
        FR_TRAIL = 3'b011,
        FR_RECAL = 3'b100,
        FR_DONE = 3'b101
    } sadc_phase_t;

endpackage

//--- rtl/sadc_sar.sv
// Successive approximation register stepped one decision at a time
`timescale 1ns/1ps
module sadc_sar #(
    parameter int W = 10
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic start_i,
    input wire logic step_i,
    input wire logic comp_i,
    // Trial code, becomes the result once done
    output logic [W-1:0] trial_o,
    output logic done_o
);

    logic [W-1:0] mask_r;

    // ------------------------------------------------------------
    // Start sets the MSB trial; each step settles the current bit
    // ------------------------------------------------------------
    // Comparator high means the input is at or above the trial level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trial_o <= '0;
            mask_r <= '0;
            done_o <= 1'b0;
        end else if (start_i) begin
            trial_o <= {1'b1, {(W-1){1'b0}}};
            mask_r <= {1'b1, {(W-1){1'b0}}};
            done_o <= 1'b0;
        end else if (step_i && !done_o) begin
            trial_o <= (trial_o & ~(mask_r & {W{~comp_i}})) | (mask_r >> 1);
            mask_r <= mask_r >> 1;
            done_o <= mask_r[0];
        end
    end

endmodule

//--- rtl/sadc_sync2.sv
// Two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module sadc_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins and synchronised levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    // ------------------------------------------------------------
    // One pair of flops per bit
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_r;
            logic sync_r;
            // First stage feeds only the second stage
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_r <= INIT[g];
                    sync_r <= INIT[g];
                end else begin
                    meta_r <= async_i[g];
                    sync_r <= meta_r;
                end
            end
            assign sync_o[g] = sync_r;
        end
    endgenerate

endmodule
